// ===== logic/srbm_supply_regulator.sv
// Supply regulator control, battery comparator select and low-voltage reset.
module srbm_supply_regulator
  import srbm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Special function register port
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  // Flash calibration read port
  input  wire logic [15:0] cal_addr_i,
  input  wire logic [7:0]  cal_flash_data_i,
  output logic      [7:0]  cal_rdata_o,
  output logic             cal_measured_o,
  output logic      [7:0]  cal_effective_o,
  // Chip state
  input  wire logic        sleep_state_i,
  input  wire logic        emulator_mode_i,
  input  wire logic        cmp_raw_i,
  // Analog controls
  output logic             regulator_enable_o,
  output logic      [2:0]  core_src_o,
  output logic             core_sel_valid_o,
  output logic             cmp_enable_o,
  output logic      [3:0]  divider_select_o,
  output logic             divider_undef_o,
  output logic             noise_filter_o,
  output logic             low_battery_detect_o,
  output logic             second_low_voltage_reset_o
);

  typedef struct packed {
    logic [7:0] option_bits;
    logic [7:0] supply_voltage_control;
    logic [7:0] comparator_select;
    logic       cmp_sync;
    logic       cmp_res;
    logic       lv_rst;
    logic [7:0] rdata;
    logic [7:0] cal;
    logic [2:0] src;
    logic       src_valid;
  } srbm_state_t;

  srbm_state_t st_reg;
  srbm_state_t st_next;
  srbm_sel_if  sel ();

  // In emulator mode the control byte is pinned to its reset value, while
  // the stored byte is kept so that leaving emulator mode restores it.
  logic [7:0] svc_eff;
  assign svc_eff = emulator_mode_i ? SRBM_SVC_RST
                                   : st_reg.supply_voltage_control;

  // Power state picks which field reaches the regulator decoder.
  assign sel.reg_en = svc_eff[SRBM_REG_EN_BIT];
  assign sel.code   = sleep_state_i ?
                      svc_eff[SRBM_SLP_SEL_LSB +: 3] :
                      svc_eff[SRBM_RUN_SEL_LSB +: 3];

  srbm_vsel_decode u_dec (
    .sel (sel)
  );

  always_comb begin
    st_next = st_reg;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        SRBM_OPTION_ADDR: st_next.option_bits = sfr_wdata_i;
        SRBM_SVC_ADDR: begin
          if (!emulator_mode_i) begin
            st_next.supply_voltage_control =
              sfr_wdata_i & SRBM_SVC_MASK;
          end
        end
        SRBM_CSEL_ADDR:   st_next.comparator_select = sfr_wdata_i;
        default: ;
      endcase
    end
    // The first stage only feeds the second, since the analog output is
    // asynchronous to this clock.
    st_next.cmp_sync = cmp_raw_i;
    // A disabled comparator holds a low result.
    st_next.cmp_res  = (st_reg.comparator_select[3:0] != SRBM_DIV_OFF)
                       && st_reg.cmp_sync;
    st_next.lv_rst = st_reg.comparator_select[SRBM_LVR_EN_BIT]
                     && !st_reg.cmp_res;
    st_next.rdata = 8'h00;
    case (sfr_addr_i)
      SRBM_OPTION_ADDR: st_next.rdata = st_reg.option_bits;
      SRBM_SVC_ADDR:    st_next.rdata = svc_eff;
      SRBM_CSEL_ADDR:   st_next.rdata = st_reg.comparator_select;
      SRBM_CRES_ADDR: begin
        // Only the compare bit lives here; the converter bits read zero.
        st_next.rdata[SRBM_CMP_RES_BIT] = st_reg.cmp_res;
      end
      default:          st_next.rdata = 8'h00;
    endcase
    st_next.cal = (cal_addr_i == SRBM_CAL_ADDR) ?
                  cal_flash_data_i : 8'h00;
    st_next.src       = sel.src;
    st_next.src_valid = sel.valid;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg                        <= '0;
      st_reg.option_bits            <= SRBM_OPTION_RST;
      st_reg.supply_voltage_control <= SRBM_SVC_RST;
      st_reg.comparator_select      <= SRBM_CSEL_RST;
      st_reg.src                    <= 3'(SRBM_SRC_BG_X275);
      st_reg.src_valid              <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  logic cal_in_range;
  assign cal_in_range = (cal_flash_data_i >= SRBM_CAL_LO) &&
                        (cal_flash_data_i <= SRBM_CAL_HI);

  assign sfr_rdata_o          = st_reg.rdata;
  assign cal_rdata_o          = st_reg.cal;
  assign cal_measured_o       = cal_in_range;
  assign cal_effective_o      = cal_in_range ? cal_flash_data_i
                                             : SRBM_CAL_DEFAULT;
  assign regulator_enable_o   = svc_eff[SRBM_REG_EN_BIT];
  assign core_src_o           = st_reg.src;
  assign core_sel_valid_o     = st_reg.src_valid;
  assign divider_select_o     = st_reg.comparator_select[3:0];
  assign cmp_enable_o         = (divider_select_o != SRBM_DIV_OFF);
  assign divider_undef_o      = (divider_select_o[3:1] == SRBM_DIV_UNDEF[3:1]);
  assign noise_filter_o       = st_reg.option_bits[SRBM_FILT_BIT];
  assign low_battery_detect_o = !st_reg.cmp_res;
  assign second_low_voltage_reset_o = st_reg.lv_rst;

  // The read data is registered, so the frozen view shows only after
  // emulator mode has stood for one full cycle.
  chk_svc_frozen_emul: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (emulator_mode_i && $past(emulator_mode_i)
       && $past(sfr_addr_i) == SRBM_SVC_ADDR)
      |-> sfr_rdata_o == SRBM_SVC_RST)
    else $error("supply control not frozen in emulator mode");

  chk_lvrst_needs_enable: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st_reg.comparator_select[SRBM_LVR_EN_BIT]
      |=> !second_low_voltage_reset_o)
    else $error("low voltage reset without enable");

  chk_lvrst_fires_low: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg.comparator_select[SRBM_LVR_EN_BIT] && !st_reg.cmp_res)
      |=> second_low_voltage_reset_o)
    else $error("low voltage reset missed");

  chk_cmp_off_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (divider_select_o == SRBM_DIV_OFF) |=> !st_reg.cmp_res)
    else $error("disabled comparator gave a high result");

  chk_reg_off_battery: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !regulator_enable_o ##1 !regulator_enable_o
      |-> core_src_o == 3'(SRBM_SRC_BATTERY))
    else $error("regulator off but core not on battery");

  chk_sleep_routing: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sleep_state_i && regulator_enable_o
       && svc_eff[2:0] == 3'h7) |=> core_src_o == 3'(SRBM_SRC_BG_X275))
    else $error("sleep select not routed");

  chk_run_invalid: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!sleep_state_i && regulator_enable_o && !svc_eff[5])
      |=> !core_sel_valid_o)
    else $error("invalid run code accepted");

  chk_run_routing: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!sleep_state_i && regulator_enable_o && svc_eff[5:3] == 3'h4)
      |=> core_src_o == 3'(SRBM_SRC_BAT_16_30))
    else $error("run select not routed");

  chk_bit7_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !svc_eff[7])
    else $error("supply control bit 7 set");

  chk_cres_low_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sfr_addr_i == SRBM_CRES_ADDR) |=> sfr_rdata_o[6:0] == 7'h00)
    else $error("comparator result low bits not zero");

  chk_cal_fallback: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !cal_measured_o |-> cal_effective_o == SRBM_CAL_DEFAULT)
    else $error("unmeasured calibration not defaulted");

  chk_cal_port: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (cal_addr_i == SRBM_CAL_ADDR)
      |=> cal_rdata_o == $past(cal_flash_data_i))
    else $error("calibration byte not returned");

  chk_filter_bit: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sfr_wr_i && sfr_addr_i == SRBM_OPTION_ADDR)
      |=> noise_filter_o == $past(sfr_wdata_i[SRBM_FILT_BIT]))
    else $error("noise filter bit not taken");
endmodule

// ===== logic/srbm_pkg.sv
// Register map, field layout and encodings of the supply regulator block.
package srbm_pkg;
  localparam logic [7:0]  SRBM_OPTION_ADDR = 8'h94;
  localparam logic [7:0]  SRBM_SVC_ADDR    = 8'hA7;
  localparam logic [7:0]  SRBM_CSEL_ADDR   = 8'hC2;
  localparam logic [7:0]  SRBM_CRES_ADDR   = 8'hC3;
  localparam logic [15:0] SRBM_CAL_ADDR    = 16'h3FFC;

  localparam logic [7:0] SRBM_OPTION_RST = 8'hC1;
  localparam logic [7:0] SRBM_SVC_RST    = 8'h7F;
  localparam logic [7:0] SRBM_CSEL_RST   = 8'h00;
  localparam logic [7:0] SRBM_SVC_MASK   = 8'h7F;

  localparam int SRBM_REG_EN_BIT  = 6;
  localparam int SRBM_RUN_SEL_LSB = 3;
  localparam int SRBM_SLP_SEL_LSB = 0;
  localparam int SRBM_FILT_BIT    = 4;
  localparam int SRBM_LVR_EN_BIT  = 7;
  localparam int SRBM_CMP_RES_BIT = 7;

  localparam logic [3:0] SRBM_DIV_OFF     = 4'h0;
  localparam logic [3:0] SRBM_DIV_UNDEF   = 4'hE;
  localparam logic [7:0] SRBM_CAL_LO      = 8'hA1;
  localparam logic [7:0] SRBM_CAL_HI      = 8'hAD;
  localparam logic [7:0] SRBM_CAL_DEFAULT = 8'hA7;

  // Core supply source chosen by the regulator path.
  typedef enum logic [2:0] {
    SRBM_SRC_BATTERY,
    SRBM_SRC_BAT_16_30,
    SRBM_SRC_BAT_17_30,
    SRBM_SRC_BAT_18_30,
    SRBM_SRC_BG_X275,
    SRBM_SRC_INVALID
  } srbm_src_t;
endpackage

// ===== logic/srbm_sel_if.sv
// Carries the active voltage select from the main block to its decoder.
interface srbm_sel_if;
  logic       reg_en;
  logic [2:0] code;
  logic [2:0] src;
  logic       valid;
  modport ctrl (output reg_en, output code, input src, input valid);
  modport dec  (input reg_en, input code, output src, output valid);
endinterface

// ===== logic/srbm_vsel_decode.sv
// Decodes the active voltage select code into a core supply source.
module srbm_vsel_decode
  import srbm_pkg::*;
(
  srbm_sel_if.dec sel
);
  srbm_src_t src;

  always_comb begin
    src = SRBM_SRC_INVALID;
    if (!sel.reg_en) begin
      src = SRBM_SRC_BATTERY;
    end else begin
      case (sel.code)
        3'h4:    src = SRBM_SRC_BAT_16_30;
        3'h5:    src = SRBM_SRC_BAT_17_30;
        3'h6:    src = SRBM_SRC_BAT_18_30;
        3'h7:    src = SRBM_SRC_BG_X275;
        default: src = SRBM_SRC_INVALID;
      endcase
    end
  end

  assign sel.src   = src;
  assign sel.valid = (src != SRBM_SRC_INVALID);
endmodule

// ===== tb/srbm_supply_regulator_tb.sv
// Self-checking testbench for the supply regulator block.
module srbm_supply_regulator_tb
  import srbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, cal_rd, cal_eff;
  logic        wr = 1'b0, slp = 1'b0, emu = 1'b0, raw = 1'b0;
  logic [15:0] cal_addr = 16'h0000;
  logic [7:0]  flash = 8'h00;
  logic [2:0]  src;
  logic [3:0]  div;
  logic        cal_meas, valid, reg_en, cmp_en, undef, filt, low_bat, lvr;
  int          bad_count = 0;
  int          total_checks = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  srbm_supply_regulator dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .cal_addr_i(cal_addr), .cal_flash_data_i(flash), .cal_rdata_o(cal_rd),
    .cal_measured_o(cal_meas), .cal_effective_o(cal_eff),
    .sleep_state_i(slp), .emulator_mode_i(emu), .cmp_raw_i(raw),
    .regulator_enable_o(reg_en), .core_src_o(src),
    .core_sel_valid_o(valid), .cmp_enable_o(cmp_en),
    .divider_select_o(div), .divider_undef_o(undef),
    .noise_filter_o(filt), .low_battery_detect_o(low_bat),
    .second_low_voltage_reset_o(lvr));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr    <= 1'b0;
    settle(1);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    settle(1);
    chk(what, exp, rdata);
  endtask

  task automatic t_reset_values();
    chk("core_src", 8'(SRBM_SRC_BG_X275), 8'(src));
    chk("lvr", 8'h00, 8'(lvr));
    rd_chk("option", SRBM_OPTION_ADDR, 8'hC1);
    rd_chk("supply ctl", SRBM_SVC_ADDR, 8'h7F);
    rd_chk("csel", SRBM_CSEL_ADDR, 8'h00);
    rd_chk("unmapped", 8'h95, 8'h00);
  endtask

  task automatic t_supply_select();
    wr_reg(SRBM_SVC_ADDR, 8'hA4);
    rd_chk("supply ctl bit7", SRBM_SVC_ADDR, 8'h24);
    chk("reg_en off", 8'h00, 8'(reg_en));
    chk("src battery", 8'(SRBM_SRC_BATTERY), 8'(src));
    wr_reg(SRBM_SVC_ADDR, 8'h65);
    settle(1);
    chk("reg_en on", 8'h01, 8'(reg_en));
    chk("run 100", 8'(SRBM_SRC_BAT_16_30), 8'(src));
    @(posedge core_clk_i);
    slp <= 1'b1;
    settle(2);
    chk("slp 101", 8'(SRBM_SRC_BAT_17_30), 8'(src));
    wr_reg(SRBM_SVC_ADDR, 8'h4E);
    settle(1);
    chk("sleep 110", 8'(SRBM_SRC_BAT_18_30), 8'(src));
    chk("sleep valid", 8'h01, 8'(valid));
    @(posedge core_clk_i);
    slp <= 1'b0;
    settle(2);
    chk("run 001 invalid", 8'h00, 8'(valid));
    wr_reg(SRBM_SVC_ADDR, 8'h7F);
    settle(1);
    chk("run 111", 8'(SRBM_SRC_BG_X275), 8'(src));
    @(posedge core_clk_i);
    slp <= 1'b1;
    settle(2);
    chk("sleep 111", 8'(SRBM_SRC_BG_X275), 8'(src));
    @(posedge core_clk_i);
    slp <= 1'b0;
  endtask

  task automatic t_emulator();
    wr_reg(SRBM_SVC_ADDR, 8'h30);
    @(posedge core_clk_i);
    emu <= 1'b1;
    wr_reg(SRBM_SVC_ADDR, 8'h00);
    rd_chk("supply ctl emu", SRBM_SVC_ADDR, 8'h7F);
    chk("reg_en emu", 8'h01, 8'(reg_en));
    chk("src emu", 8'(SRBM_SRC_BG_X275), 8'(src));
    @(posedge core_clk_i);
    emu <= 1'b0;
    rd_chk("supply ctl kept", SRBM_SVC_ADDR, 8'h30);
    wr_reg(SRBM_SVC_ADDR, 8'h7F);
  endtask

  task automatic t_comparator();
    chk("cmp off", 8'h00, 8'(cmp_en));
    wr_reg(SRBM_CSEL_ADDR, 8'h0E);
    chk("undef", 8'h01, 8'(undef));
    chk("div", 8'h0E, 8'(div));
    wr_reg(SRBM_CSEL_ADDR, 8'h08);
    chk("cmp on", 8'h01, 8'(cmp_en));
    chk("defined", 8'h00, 8'(undef));
    @(posedge core_clk_i);
    raw <= 1'b1;
    settle(4);
    rd_chk("cmp result high", SRBM_CRES_ADDR, 8'h80);
    chk("low bat clear", 8'h00, 8'(low_bat));
    wr_reg(SRBM_CRES_ADDR, 8'h00);
    chk("result read only", 8'h80, rdata);
    wr_reg(SRBM_CSEL_ADDR, 8'h88);
    settle(4);
    chk("no reset", 8'h00, 8'(lvr));
    @(posedge core_clk_i);
    raw <= 1'b0;
    settle(4);
    chk("reset req", 8'h01, 8'(lvr));
    chk("low bat set", 8'h01, 8'(low_bat));
    wr_reg(SRBM_CSEL_ADDR, 8'h08);
    settle(2);
    chk("reset off", 8'h00, 8'(lvr));
  endtask

  task automatic t_filter_and_cal();
    wr_reg(SRBM_OPTION_ADDR, 8'hD1);
    chk("filter", 8'h01, 8'(filt));
    rd_chk("option rw", SRBM_OPTION_ADDR, 8'hD1);
    wr_reg(SRBM_OPTION_ADDR, 8'hC1);
    chk("filter off", 8'h00, 8'(filt));
    @(posedge core_clk_i);
    cal_addr <= SRBM_CAL_ADDR;
    flash    <= 8'hAD;
    settle(2);
    chk("cal rd", 8'hAD, cal_rd);
    chk("cal meas", 8'h01, 8'(cal_meas));
    chk("cal eff meas", 8'hAD, cal_eff);
    @(posedge core_clk_i);
    flash <= 8'hAE;
    settle(2);
    chk("cal unmeas", 8'h00, 8'(cal_meas));
    chk("cal eff", 8'hA7, cal_eff);
    @(posedge core_clk_i);
    cal_addr <= 16'h3FFB;
    settle(2);
    chk("cal other addr", 8'h00, cal_rd);
  endtask

  // A reset in mid-run must bring back the defaults after user writes.
  task automatic t_mid_reset();
    wr_reg(SRBM_SVC_ADDR, 8'h24);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    chk("src after reset", 8'(SRBM_SRC_BG_X275), 8'(src));
    chk("lvr after reset", 8'h00, 8'(lvr));
    rd_chk("supply ctl reset", SRBM_SVC_ADDR, 8'h7F);
    rd_chk("csel reset", SRBM_CSEL_ADDR, 8'h00);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #50us;
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    t_reset_values();
    t_supply_select();
    t_emulator();
    t_comparator();
    t_filter_and_cal();
    t_mid_reset();
    end_sim();
  end
endmodule
